//--- src/shcf_fifo.sv
`timescale 1ns/1ns
module shcf_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             rdy_ff, nxt_rdy;
    logic             push, pop;

    // ready is registered so the source sees a clean level
    assign push      = in_valid && rdy_ff;
    assign pop       = out_ready && (cnt_ff != '0);
    assign in_ready  = rdy_ff;
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];

    // pointer and count next values
    always_comb begin
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        nxt_rdy = (nxt_cnt != FULL);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    // storage needs no reset, guarded by the count
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

//--- src/shcf_framer.sv
`include "shcf_map.svh"
`timescale 1ns/1ns
module shcf_framer
    import shcf_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [`SHCF_PAYLOAD_W-1:0] in_data,
    input  wire logic                       sysref_in,
    input  wire logic [`SHCF_BLK_CNT_W-1:0] emb_multiblocks_minus1,
    input  wire logic [1:0]                 header_stream_format_select,
    output logic      [`SHCF_BLOCK_W-1:0]   tx_block_ff,
    output logic                            tx_valid_ff,
    output logic                            local_extended_multiblock_clock_ff,
    output logic                            underflow_ff
);
    shcf_state_type                state_ff, nxt_state;
    logic [`SHCF_BLK_CNT_W-1:0]    blk_ff, nxt_blk;
    logic [`SHCF_BLK_CNT_W-1:0]    mb_ff, nxt_mb;
    logic [`SHCF_BLK_CNT_W-1:0]    out_blk_ff, nxt_out_blk;
    logic                          out_last_ff, nxt_out_last;
    logic                          fec_ff, nxt_fec;
    logic                          out_fec_ff, nxt_out_fec;
    logic [`SHCF_FEC_W-1:0]        par_ff, nxt_par;
    logic [`SHCF_FEC_W-1:0]        hold_ff, nxt_hold;
    logic                          sysref_d_ff;
    logic [`SHCF_BLOCK_W-1:0]      nxt_block;
    logic                          nxt_valid, nxt_emb_clk, nxt_under;
    logic                          sysref_edge, last_mb, fifo_valid, pop;
    logic [`SHCF_PAYLOAD_W-1:0]    fifo_data, payload;
    logic [31:0]                   stream;

    // serial parity register, 64 payload bits per block, bit 0 first
    function automatic logic [`SHCF_FEC_W-1:0] shcf_parity_step(
        input logic [`SHCF_FEC_W-1:0]     s,
        input logic [`SHCF_PAYLOAD_W-1:0] d,
        input logic                       fec
    );
        logic [`SHCF_FEC_W-1:0] r;
        logic [`SHCF_FEC_W-1:0] crc_taps;
        logic                   fb;
        r        = s;
        crc_taps = {14'h0000, `SHCF_CRC_POLY};
        crc_taps = {crc_taps[`SHCF_FEC_W-2:0], 1'b1};
        crc_taps[`SHCF_CRC_W] = 1'b0;
        for (int i = 0; i < `SHCF_PAYLOAD_W; i++) begin
            if (fec) begin
                fb = d[i] ^ r[`SHCF_FEC_W-1];
                r  = {r[`SHCF_FEC_W-2:0], 1'b0} ^ (fb ? `SHCF_FEC_TAPS : `SHCF_PAR_CLEAR);
            end else begin
                fb = d[i] ^ r[`SHCF_CRC_W-1];
                r  = {r[`SHCF_FEC_W-2:0], 1'b0} ^ (fb ? crc_taps : `SHCF_PAR_CLEAR);
                r[`SHCF_FEC_W-1:`SHCF_CRC_W] = '0;
            end
        end
        return r;
    endfunction

    // 32-bit header stream, element n is sent in block n
    function automatic logic [31:0] shcf_stream(
        input logic [`SHCF_FEC_W-1:0] p,
        input logic                   fec,
        input logic                   emb_end
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (fec) begin
            for (int k = 0; k < 22; k++) begin
                w[k] = p[`SHCF_FEC_W-1-k];
            end
            w[23] = p[3];
            w[24] = p[2];
            w[25] = p[1];
            w[26] = p[0];
        end else begin
            for (int g = 0; g < 4; g++) begin
                w[4*g]   = p[`SHCF_CRC_W-1-3*g];
                w[4*g+1] = p[`SHCF_CRC_W-2-3*g];
                w[4*g+2] = p[`SHCF_CRC_W-3-3*g];
                w[4*g+3] = 1'b1;
            end
            w[18:16] = 3'h0;
            w[20]    = 1'b0;
            w[26:24] = 3'h0;
            w[19] = 1'b1;
            w[21] = 1'b1;
            w[23] = 1'b1;
        end
        w[`SHCF_EMB_END_POS] = emb_end;
        w[`SHCF_PILOT_LAST:`SHCF_PILOT_FIRST] = 4'h0;
        w[`SHCF_PILOT_POS] = 1'b1;
        return w;
    endfunction

    // input buffer; held full until the first sysref starts framing
    shcf_fifo #(
        .WIDTH (`SHCF_PAYLOAD_W),
        .DEPTH (`SHCF_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // sysref treated as synchronous; any rising edge realigns
    assign sysref_edge = sysref_in && !sysref_d_ff;
    assign last_mb = (mb_ff == emb_multiblocks_minus1);
    assign pop     = (state_ff == SHCF_RUN) && !sysref_edge;
    // line must keep going; an empty buffer sends a zero payload
    assign payload = fifo_valid ? fifo_data : '0;
    assign stream  = shcf_stream(hold_ff, fec_ff, last_mb);

    // framing counters, parity and output block
    always_comb begin
        nxt_state    = state_ff;
        nxt_blk      = blk_ff;
        nxt_mb       = mb_ff;
        nxt_fec      = fec_ff;
        nxt_par      = par_ff;
        nxt_hold     = hold_ff;
        nxt_block    = tx_block_ff;
        nxt_valid    = 1'b0;
        nxt_emb_clk  = 1'b0;
        nxt_under    = 1'b0;
        nxt_out_blk  = out_blk_ff;
        nxt_out_last = out_last_ff;
        nxt_out_fec  = out_fec_ff;
        case (state_ff)
            SHCF_IDLE: begin
                nxt_block = '0;
            end
            SHCF_RUN: begin
                nxt_valid = 1'b1;
                nxt_under = !fifo_valid;
                // one sent as 01, zero as 10
                // stream bit n in block n
                nxt_block = {payload, stream[blk_ff] ? `SHCF_HDR_ONE : `SHCF_HDR_ZERO};
                nxt_out_blk  = blk_ff;
                nxt_out_last = last_mb;
                nxt_out_fec  = fec_ff;
                // clock edge at block 0 of multiblock 0
                nxt_emb_clk = (blk_ff == `SHCF_FIRST_BLK) && (mb_ff == `SHCF_FIRST_MB);
                nxt_par = shcf_parity_step(par_ff, payload, fec_ff);
                if (blk_ff == `SHCF_LAST_BLK) begin
                    nxt_blk  = `SHCF_FIRST_BLK;
                    nxt_hold = nxt_par;
                    nxt_par  = `SHCF_PAR_CLEAR;
                    nxt_mb   = last_mb ? `SHCF_FIRST_MB : mb_ff + 1'b1;
                end else begin
                    nxt_blk = blk_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = SHCF_IDLE;
            end
        endcase
        // periodic edges land on block 0 anyway
        if (sysref_edge) begin
            nxt_state = SHCF_RUN;
            nxt_blk   = `SHCF_FIRST_BLK;
            nxt_mb    = `SHCF_FIRST_MB;
            nxt_par   = `SHCF_PAR_CLEAR;
            nxt_hold  = `SHCF_PAR_CLEAR;
            // fec only on code 2, else crc-12
            nxt_fec   = (header_stream_format_select == `SHCF_FMT_FEC);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_ff                           <= SHCF_IDLE;
            blk_ff                             <= '0;
            mb_ff                              <= '0;
            fec_ff                             <= 1'b0;
            par_ff                             <= '0;
            hold_ff                            <= '0;
            sysref_d_ff                        <= 1'b0;
            tx_block_ff                        <= '0;
            tx_valid_ff                        <= 1'b0;
            local_extended_multiblock_clock_ff <= 1'b0;
            underflow_ff                       <= 1'b0;
            out_blk_ff                         <= '0;
            out_last_ff                        <= 1'b0;
            out_fec_ff                         <= 1'b0;
        end else begin
            state_ff                           <= nxt_state;
            blk_ff                             <= nxt_blk;
            mb_ff                              <= nxt_mb;
            fec_ff                             <= nxt_fec;
            par_ff                             <= nxt_par;
            hold_ff                            <= nxt_hold;
            sysref_d_ff                        <= sysref_in;
            tx_block_ff                        <= nxt_block;
            tx_valid_ff                        <= nxt_valid;
            local_extended_multiblock_clock_ff <= nxt_emb_clk;
            underflow_ff                       <= nxt_under;
            out_blk_ff                         <= nxt_out_blk;
            out_last_ff                        <= nxt_out_last;
            out_fec_ff                         <= nxt_out_fec;
        end
    end

    // checks on the emitted stream
    sequence s_mb_end;
        tx_valid_ff && (out_blk_ff == `SHCF_LAST_BLK);
    endsequence

    sequence s_next_mb_start;
        tx_valid_ff && (out_blk_ff == `SHCF_FIRST_BLK);
    endsequence

    AST_HDR_COMPLEMENT: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        tx_valid_ff |-> (tx_block_ff[0] != tx_block_ff[1]))
        else $error("header bits not complementary");

    AST_PILOT_ONE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        s_mb_end |-> (tx_block_ff[1:0] == `SHCF_HDR_ONE))
        else $error("pilot final one missing");

    AST_PILOT_ZEROS: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (tx_valid_ff && out_blk_ff >= 5'h1B && out_blk_ff <= 5'h1E)
        |-> (tx_block_ff[1:0] == `SHCF_HDR_ZERO))
        else $error("pilot zero position not zero");

    AST_MB_LENGTH: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (s_mb_end ##1 !sysref_d_ff) |-> s_next_mb_start)
        else $error("multiblock not 32 blocks");

    AST_EXTENDED_MULTIBLOCK_END_FLAG_BIT: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (tx_valid_ff && out_blk_ff == 5'h16)
        |-> (tx_block_ff[1:0] == (out_last_ff ? `SHCF_HDR_ONE : `SHCF_HDR_ZERO)))
        else $error("end of extended multiblock bit wrong");

    AST_CRC_CLEAR: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (state_ff == SHCF_RUN && blk_ff == `SHCF_LAST_BLK && !sysref_edge)
        |=> (par_ff == `SHCF_PAR_CLEAR) && (blk_ff == `SHCF_FIRST_BLK))
        else $error("parity not cleared at multiblock start");

    AST_CMD_ZERO: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (tx_valid_ff && !out_fec_ff && (out_blk_ff == 5'h10 || out_blk_ff == 5'h14 || out_blk_ff == 5'h19))
        |-> (tx_block_ff[1:0] == `SHCF_HDR_ZERO))
        else $error("command position not zero");

    AST_FIXED_ONES: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (tx_valid_ff && !out_fec_ff && (out_blk_ff == 5'h03 || out_blk_ff == 5'h13 || out_blk_ff == 5'h17))
        |-> (tx_block_ff[1:0] == `SHCF_HDR_ONE))
        else $error("fixed one missing");

    AST_LOCAL_EXTENDED_MULTIBLOCK_CLOCK_START: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        sysref_edge |=> ##1 (local_extended_multiblock_clock_ff && tx_valid_ff && out_blk_ff == `SHCF_FIRST_BLK))
        else $error("extended multiblock clock not realigned");
endmodule

//--- src/shcf_map.svh
`ifndef SHCF_MAP_SVH
`define SHCF_MAP_SVH

// block geometry
`define SHCF_OCTETS       8
`define SHCF_PAYLOAD_W    64
`define SHCF_BLOCK_W      66
`define SHCF_HDR_W        2
`define SHCF_BLK_CNT_W    5
`define SHCF_LAST_BLK     5'h1F
`define SHCF_FIRST_BLK    5'h00
`define SHCF_FIRST_MB     5'h00
// header codes as vector [1:0]; bit 0 is sent first
`define SHCF_HDR_ONE      2'h2
`define SHCF_HDR_ZERO     2'h1
// header stream format select codes
`define SHCF_FMT_CRC12    2'h0
`define SHCF_FMT_FEC      2'h2
// parity generators
`define SHCF_CRC_W        12
`define SHCF_FEC_W        26
`define SHCF_CRC_POLY     12'h987
`define SHCF_FEC_TAPS     26'h0220211
`define SHCF_PAR_CLEAR    26'h0000000
// stream positions and input buffer depth
`define SHCF_EMB_END_POS  22
`define SHCF_PILOT_POS    31
`define SHCF_PILOT_FIRST  27
`define SHCF_PILOT_LAST   30
`define SHCF_FIFO_DEPTH   4

`endif

//--- src/shcf_pkg.sv
package shcf_pkg;
    // framer run state, one-hot
    typedef enum logic [1:0] {
        SHCF_IDLE = 2'h1,
        SHCF_RUN  = 2'h2
    } shcf_state_type;
endpackage

//--- tb/shcf_rx_model.sv
`timescale 1ns/1ns
module shcf_rx_model (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [65:0] tx_block_ff,
    input  wire logic        tx_valid_ff,
    input  wire logic        local_extended_multiblock_clock_ff,
    input  wire logic        underflow_ff,
    input  wire logic        sysref_in,
    input  wire logic [4:0]  emb_multiblocks_minus1,
    input  wire logic [1:0]  header_stream_format_select,
    output int               mb_done,
    output int               err_count
);
    logic [31:0] strm;
    logic [11:0] crc;
    logic [11:0] prv;
    logic [4:0]  em_l;
    logic [1:0]  fmt_l;
    logic        fresh;
    logic        sref_d;
    int          bi;
    int          mi;
    // receiver side: recount blocks, rebuild the header stream, recheck crc-12 parity
    always @(posedge clk_sys) begin
        logic fb;
        if (!reset_n) begin
            mb_done = 0;
            err_count = 0;
            fresh = 1'h1;
            sref_d = 1'h0;
            bi = 0;
            mi = 0;
            crc = 12'h000;
            prv = 12'h000;
        end else begin
            if (sysref_in && !sref_d) fresh = 1'h1;
            sref_d = sysref_in;
            if (tx_valid_ff) begin
                // phase of the extended multiblock clock
                if (local_extended_multiblock_clock_ff) begin
                    if (!fresh && (bi != 31 || mi != em_l)) err_count++;
                    // first multiblock after a restart carries zero parity
                    if (fresh) prv = 12'h000;
                    if (fresh) em_l = emb_multiblocks_minus1;
                    if (fresh) fmt_l = header_stream_format_select;
                    fresh = 1'h0;
                    bi = 0;
                    mi = 0;
                end else if (bi == 31) begin
                    bi = 0;
                    mi++;
                    if (mi > em_l) err_count++;
                end else begin
                    bi++;
                end
                if (bi == 0) crc = 12'h000;
                if (tx_block_ff[0] == tx_block_ff[1]) err_count++;
                if (!underflow_ff && tx_block_ff[65:34] !== ~tx_block_ff[33:2]) err_count++;
                strm[bi] = tx_block_ff[1];
                // shift-left generator, payload bit 0 first
                for (int k = 2; k < 66; k++) begin
                    fb = tx_block_ff[k] ^ crc[11];
                    crc = {crc[10:0], 1'h0} ^ (fb ? 12'h30F : 12'h000);
                end
                if (bi == 31) begin
                    mb_done++;
                    if (strm[31:27] !== 5'h10) err_count++;
                    if (strm[22] !== (mi == em_l)) err_count++;
                    // carried parity must match the previous multiblock
                    if (fmt_l != 2'h2) begin
                        if ({strm[0], strm[1], strm[2], strm[4], strm[5], strm[6], strm[8], strm[9],
                             strm[10], strm[12], strm[13], strm[14]} !== prv) err_count++;
                        if ({strm[3], strm[7], strm[11], strm[15], strm[19], strm[21], strm[23]} !== 7'h7F)
                            err_count++;
                        if ({strm[16], strm[17], strm[18], strm[20], strm[24], strm[25], strm[26]} !== 7'h00)
                            err_count++;
                    end
                    prv = crc;
                end
            end
        end
    end
endmodule

//--- tb/testbench.sv
`include "shcf_map.svh"
`timescale 1ns/1ns
module testbench;
    logic                       clk_sys;
    logic                       reset_n;
    logic                       in_valid;
    logic                       in_ready;
    logic [`SHCF_PAYLOAD_W-1:0] in_data;
    logic                       sysref_in;
    logic [4:0]                 emb_multiblocks_minus1;
    logic [1:0]                 header_stream_format_select;
    logic [`SHCF_BLOCK_W-1:0]   tx_block_ff;
    logic                       tx_valid_ff;
    logic                       emb_clk;
    logic                       underflow_ff;
    logic                       feed_en;
    logic [31:0]                word_n;
    int                         mb_done;
    int                         err_count;
    int                         fail_count;
    int                         checks_done;

    shcf_framer i_shcf_framer (
        .clk_sys                            (clk_sys),
        .reset_n                            (reset_n),
        .in_valid                           (in_valid),
        .in_ready                           (in_ready),
        .in_data                            (in_data),
        .sysref_in                          (sysref_in),
        .emb_multiblocks_minus1             (emb_multiblocks_minus1),
        .header_stream_format_select        (header_stream_format_select),
        .tx_block_ff                        (tx_block_ff),
        .tx_valid_ff                        (tx_valid_ff),
        .local_extended_multiblock_clock_ff (emb_clk),
        .underflow_ff                       (underflow_ff)
    );
    shcf_rx_model i_shcf_rx_model (
        .clk_sys                            (clk_sys),
        .reset_n                            (reset_n),
        .tx_block_ff                        (tx_block_ff),
        .tx_valid_ff                        (tx_valid_ff),
        .local_extended_multiblock_clock_ff (emb_clk),
        .underflow_ff                       (underflow_ff),
        .sysref_in                          (sysref_in),
        .emb_multiblocks_minus1             (emb_multiblocks_minus1),
        .header_stream_format_select        (header_stream_format_select),
        .mb_done                            (mb_done),
        .err_count                          (err_count)
    );

    // upper half is the complement of the lower half so the receiver can spot octet slips
    function automatic logic [63:0] pat(input logic [31:0] n);
        return {~n, n};
    endfunction

    always #25 clk_sys = ~clk_sys;
    // feeder holds each word until the buffer takes it
    always @(posedge clk_sys) if (in_valid && in_ready) word_n <= word_n + 32'h1;
    always @(negedge clk_sys) begin
        in_valid <= feed_en;
        in_data  <= pat(word_n);
    end

    task automatic check_val(input logic [65:0] got, input logic [65:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    task automatic check_int(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // idle framer fills the buffer, then refuses further words
    task automatic t_fill();
        @(negedge clk_sys);
        check_val(in_ready, 66'h1, "ready after reset");
        check_val(tx_valid_ff, 66'h0, "framer idle before sysref");
        feed_en = 1'h1;
        repeat (8) @(negedge clk_sys);
        check_val(in_ready, 66'h0, "buffer full");
        check_val(word_n, 66'h4, "four words taken");
        $display("test fill done");
    endtask

    // restart on sysref, then let the receiver model judge a few multiblocks
    task automatic t_frame(input logic [1:0] fmt, input logic [4:0] em1, input bit first);
        int m0;
        int e0;
        int len;
        m0 = mb_done;
        e0 = err_count;
        len = 32 * (em1 + 1);
        @(negedge clk_sys);
        header_stream_format_select = fmt;
        emb_multiblocks_minus1 = em1;
        sysref_in = 1'h1;
        // block 0 stands between the second and third edge after sysref
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        sysref_in = 1'h0;
        check_val(emb_clk, 66'h1, "clock pulse with block 0");
        check_val(tx_valid_ff, 66'h1, "running");
        check_val(tx_block_ff[1:0], 66'h1, "first header carries zero");
        if (first) check_val(tx_block_ff[65:2], pat(32'h0), "first payload");
        repeat (len - 1) @(negedge clk_sys);
        check_val(emb_clk, 66'h0, "no pulse before period end");
        @(negedge clk_sys);
        check_val(emb_clk, 66'h1, "pulse at period end");
        // periodic sysref rising with the last block must keep the phase
        repeat (len - 2) @(negedge clk_sys);
        sysref_in = 1'h1;
        @(negedge clk_sys);
        sysref_in = 1'h0;
        check_val(emb_clk, 66'h0, "no pulse on last block");
        @(negedge clk_sys);
        check_val(emb_clk, 66'h1, "periodic sysref keeps phase");
        repeat (40) @(negedge clk_sys);
        check_int(mb_done - m0 >= 2 * (em1 + 1), 1, "multiblocks seen");
        check_int(err_count - e0, 0, "receiver errors");
        $display("test frame fmt %0d e %0d done", fmt, em1 + 1);
    endtask

    // starved buffer gives zero payload but keeps framing
    task automatic t_underflow();
        int n;
        feed_en = 1'h0;
        n = 0;
        while (underflow_ff !== 1'h1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check_val(underflow_ff, 66'h1, "underflow seen");
        check_val(tx_block_ff[65:2], 66'h0, "zero payload");
        check_val(tx_block_ff[0] ^ tx_block_ff[1], 66'h1, "header still toggles");
        feed_en = 1'h1;
        $display("test underflow done");
    endtask

    initial begin
        clk_sys = 1'h0;
        reset_n = 1'h0;
        in_valid = 1'h0;
        in_data = 64'h0;
        sysref_in = 1'h0;
        emb_multiblocks_minus1 = 5'h00;
        header_stream_format_select = 2'h0;
        feed_en = 1'h0;
        word_n = 32'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'h1;
        t_fill();
        t_frame(2'h0, 5'h01, 1'h1);
        t_frame(2'h1, 5'h00, 1'h0);
        t_frame(2'h3, 5'h02, 1'h0);
        t_frame(2'h2, 5'h00, 1'h0);
        t_underflow();
        t_frame(2'h0, 5'h00, 1'h0);
        summarize();
    end

    // watchdog sized well past the expected run of under eight hundred cycles
    initial begin
        #(5000 * 50);
        fail_count++;
        summarize();
    end
endmodule
